//--- shared/tile_status_params.svh
// Offsets, field positions, reset values and timing counts of the tile status registers.
`ifndef TILE_STATUS_PARAMS_SVH
`define TILE_STATUS_PARAMS_SVH
`define REG_FEATURE_CONTROL   8'h02
`define REG_BOOT_REPORT       8'h03
`define REG_SECURITY          8'h05
`define REG_OSC_RUN           8'h06
`define REG_OSC_COUNT_FIRST   8'h07
`define REG_OSC_COUNT_LAST    8'h0A
`define PS_RESOURCE_TYPE      8'h0B
`define PS_REG_SHIFT          8
`define FC_DELAY_MSB          25
`define FC_DELAY_LSB          18
`define FC_DIV_MSB            17
`define FC_DIV_LSB            9
`define FC_RGMII_EN_BIT       8
`define FC_DYNAMIC_BIT        5
`define FC_LP_DIV_BIT         4
`define FC_UTMI_SEL_BIT       2
`define FC_ULPI_HW_BIT        1
`define FC_WRITE_MASK         32'h03FF_FF36
`define FC_RESET              32'h0000_0000
`define SEC_LOCK_BIT          31
`define SEC_WRITE_MASK        32'h8000_5FB1
`define OSC_RUN_MASK          32'h0000_0003
`define OSC_CORE_BIT          1
`define OSC_PERIPH_BIT        0
`define OSC_COUNT_WIDTH       16
`define BOOT_PROC_LSB         16
`define BOOT_OVERRIDE_BIT     8
`define BOOT_CORE1_OFF_BIT    5
`define BOOT_SKIP_POLL_BIT    4
`define BOOT_FROM_RAM_BIT     3
`define BOOT_FROM_JTAG_BIT    2
`define OSC_SETTLE_CYCLES     10
`endif

//--- shared/tile_status_pkg.sv
// Types shared by the tile status register bank.
package tile_status_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  reg_num_t;
  typedef enum logic [1:0] {
    PLL_FULL   = 2'b00,
    PLL_SLOWED = 2'b01
  } lp_state_t;
endpackage : tile_status_pkg

//--- rtl/ring_osc_counter.sv
// One free-running ring-oscillator counter with its sampled tile-clock copy.
`timescale 1ns/1ps
module ring_osc_counter
  import tile_status_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             osc_clk_in,
  input  wire logic             run_in,
  input  wire logic             sys_clk_in,
  output logic      [WIDTH-1:0] count_out
);
  // *******************************************************************
  // Counter on the oscillator
  // *******************************************************************
  // No reset: the count survives a system reset.
  // It powers up at zero, so a read before the first run is still defined.
  logic [WIDTH-1:0] count = '0;
  logic             run_meta;
  logic             run_sync;
  logic [WIDTH-1:0] sample_meta;
  logic [WIDTH-1:0] next_count;

  initial begin
    if (WIDTH < 1) $error("ring_osc_counter width must be positive");
  end

  assign next_count = count + WIDTH'(1);

  // The oscillator may toggle before the enable is defined; an unknown enable holds the count.
  always_ff @(posedge osc_clk_in) begin
    run_meta <= run_in;
    run_sync <= run_meta;
    if (run_sync) begin
      count <= next_count;
    end
  end

  // *******************************************************************
  // Tile clock sample
  // *******************************************************************
  // Value only settles once the oscillator has stopped.
  always_ff @(posedge sys_clk_in) begin
    sample_meta <= count;
    count_out   <= sample_meta;
  end
endmodule : ring_osc_counter

//--- rtl/tile_status_control_regs.sv
// Processor-status register bank of one processor tile.
//
// Contract
// - Ethernet transmit delay field bits 25:18, reset zero
// - PLL counter toggles transmit clock at divider
// - Bit 8 enables Ethernet peripheral ports
// - Bit 4 enables low-power PLL divider
// - Bit 5 selects dynamic, paused-only division
// - Bit 2 selects UTMI, clear selects ULPI
// - Bit 1 enables ULPI hardware support
// - Boot report is read-only, processor number
// - Boot report override, core off, poll, pins
// - Boot report bits for RAM, JTAG boot
// - Security bit 31 blocks further writes
// - Security bits disable debug and JTAG access
// - Security bits control OTP locks and boot
// - Security register loads from OTP word
// - Four free-running oscillators clock counters
// - Control bits enable core, peripheral oscillators
// - Four count registers 0x07 to 0x0A
// - Counts survive a system reset
// - Oscillators run asynchronously to tile clock
// - Resource identifier is number shifted, ORed 0x0B
`timescale 1ns/1ps
`include "tile_status_params.svh"
module tile_status_control_regs
  import tile_status_pkg::*;
#(
  parameter int DIV_WIDTH = 9,
  parameter int DLY_WIDTH = 8
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ps_write_in,
  input  wire logic        ps_read_in,
  input  wire logic [31:0] ps_resource_in,
  input  wire logic [31:0] ps_wdata_in,
  output logic      [31:0] ps_rdata_out,
  output logic             ps_rvalid_out,
  output logic             ps_error_out,
  input  wire logic        pll_clk_in,
  input  wire logic [31:0] boot_report_in,
  input  wire logic [31:0] otp_security_in,
  input  wire logic        otp_load_in,
  input  wire logic        all_threads_paused_in,
  input  wire logic [3:0]  osc_clk_in,
  output logic             rgmii_tx_clk_out,
  output logic [7:0]       rgmii_tx_delay_out,
  output logic             rgmii_ports_en_out,
  output logic             lp_divide_out,
  output logic             utmi_select_out,
  output logic             ulpi_hw_en_out,
  output logic [31:0]      security_out,
  output logic [1:0]       osc_run_out
);
  // *******************************************************************
  // Elaboration checks
  // *******************************************************************
  initial begin
    if (DIV_WIDTH != `FC_DIV_MSB - `FC_DIV_LSB + 1) $error("divider width mismatch");
    if (DLY_WIDTH != `FC_DELAY_MSB - `FC_DELAY_LSB + 1) $error("delay width mismatch");
  end

  // *******************************************************************
  // Register state
  // *******************************************************************
  word_t     feature_control;
  word_t     security_settings;
  word_t     osc_run_control;
  word_t     boot_meta;
  word_t     boot_sync;
  word_t     boot_report;
  logic      boot_caught;
  logic [1:0] boot_wait;
  logic      otp_meta;
  logic      otp_sync;
  logic      otp_seen;
  logic      paused_meta;
  logic      paused_sync;
  lp_state_t lp_state;
  lp_state_t next_lp_state;

  // *******************************************************************
  // Address decode
  // *******************************************************************
  // Only the processor-status resource type is served here.
  reg_num_t reg_num;
  logic     is_ps;
  logic     hit_fc;
  logic     hit_boot;
  logic     hit_sec;
  logic     hit_osc;
  logic     hit_count;
  logic     mapped;
  logic     sec_writable;
  logic [1:0] count_sel;
  logic [`OSC_COUNT_WIDTH-1:0] counts [4];

  assign reg_num   = ps_resource_in[15:8];
  assign is_ps     = (ps_resource_in[7:0] == `PS_RESOURCE_TYPE) &&
                     (ps_resource_in[31:16] == 16'h0000);
  assign hit_fc    = is_ps && (reg_num == `REG_FEATURE_CONTROL);
  assign hit_boot  = is_ps && (reg_num == `REG_BOOT_REPORT);
  assign hit_sec   = is_ps && (reg_num == `REG_SECURITY);
  assign hit_osc   = is_ps && (reg_num == `REG_OSC_RUN);
  assign hit_count = is_ps && (reg_num >= `REG_OSC_COUNT_FIRST) &&
                     (reg_num <= `REG_OSC_COUNT_LAST);
  assign mapped    = hit_fc || hit_boot || hit_sec || hit_osc || hit_count;
  assign count_sel = 2'(reg_num - `REG_OSC_COUNT_FIRST);
  assign sec_writable = !security_settings[`SEC_LOCK_BIT];

  // *******************************************************************
  // Writable registers
  // *******************************************************************
  // Masks keep reserved positions at zero.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      feature_control <= `FC_RESET;
      osc_run_control <= 32'h0000_0000;
    end else if (ps_write_in && hit_fc) begin
      feature_control <= ps_wdata_in & `FC_WRITE_MASK;
    end else if (ps_write_in && hit_osc) begin
      osc_run_control <= ps_wdata_in & `OSC_RUN_MASK;
    end
  end

  // The OTP load arrives from the fuse controller, off this clock.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      otp_meta <= 1'b0;
      otp_sync <= 1'b0;
      otp_seen <= 1'b0;
    end else begin
      otp_meta <= otp_load_in;
      otp_sync <= otp_meta;
      otp_seen <= otp_sync;
    end
  end

  // Loading from OTP overrides the lock; only software writes are blocked.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      security_settings <= 32'h0000_0000;
    end else if (otp_sync && !otp_seen) begin
      security_settings <= otp_security_in & `SEC_WRITE_MASK;
    end else if (ps_write_in && hit_sec && sec_writable) begin
      security_settings <= ps_wdata_in & `SEC_WRITE_MASK;
    end
  end

  // *******************************************************************
  // Boot report capture
  // *******************************************************************
  // Straps are caught once after reset release, through two stages.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boot_meta   <= 32'h0000_0000;
      boot_sync   <= 32'h0000_0000;
      boot_report <= 32'h0000_0000;
      boot_caught <= 1'b0;
      boot_wait   <= 2'h0;
    end else begin
      boot_meta <= boot_report_in;
      boot_sync <= boot_meta;
      // The first two edges only fill the synchroniser, so catching earlier would store zero.
      if (boot_wait != 2'h2) begin
        boot_wait <= boot_wait + 2'h1;
      end else if (!boot_caught) begin
        boot_report <= boot_sync & 32'h00FF_013F;
        boot_caught <= 1'b1;
      end
    end
  end

  // *******************************************************************
  // Read path
  // *******************************************************************
  word_t read_word;
  assign read_word = hit_fc    ? feature_control :
                     hit_boot  ? boot_report :
                     hit_sec   ? security_settings :
                     hit_osc   ? osc_run_control :
                     hit_count ? {16'h0000, counts[count_sel]} :
                     32'h0000_0000;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ps_rdata_out  <= 32'h0000_0000;
      ps_rvalid_out <= 1'b0;
      ps_error_out  <= 1'b0;
    end else begin
      ps_rdata_out  <= ps_read_in ? read_word : 32'h0000_0000;
      ps_rvalid_out <= ps_read_in;
      ps_error_out  <= (ps_read_in || ps_write_in) && !mapped;
    end
  end

  // *******************************************************************
  // Low-power divider mode
  // *******************************************************************
  // Thread pause status comes from the scheduler; synchronise to be safe.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      paused_meta <= 1'b0;
      paused_sync <= 1'b0;
    end else begin
      paused_meta <= all_threads_paused_in;
      paused_sync <= paused_meta;
    end
  end

  logic lp_want;
  assign lp_want = feature_control[`FC_LP_DIV_BIT] &&
                   (!feature_control[`FC_DYNAMIC_BIT] || paused_sync);

  always_comb begin
    next_lp_state = lp_state;
    unique case (lp_state)
      PLL_FULL:   if (lp_want) next_lp_state = PLL_SLOWED;
      PLL_SLOWED: if (!lp_want) next_lp_state = PLL_FULL;
      default:    next_lp_state = PLL_FULL;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lp_state           <= PLL_FULL;
      lp_divide_out      <= 1'b0;
      rgmii_ports_en_out <= 1'b0;
      utmi_select_out    <= 1'b0;
      ulpi_hw_en_out     <= 1'b0;
      rgmii_tx_delay_out <= 8'h00;
      security_out       <= 32'h0000_0000;
      osc_run_out        <= 2'b00;
    end else begin
      lp_state           <= next_lp_state;
      lp_divide_out      <= (next_lp_state == PLL_SLOWED);
      rgmii_ports_en_out <= feature_control[`FC_RGMII_EN_BIT];
      utmi_select_out    <= feature_control[`FC_UTMI_SEL_BIT];
      ulpi_hw_en_out     <= feature_control[`FC_ULPI_HW_BIT];
      rgmii_tx_delay_out <= feature_control[`FC_DELAY_MSB:`FC_DELAY_LSB];
      security_out       <= security_settings;
      osc_run_out        <= osc_run_control[1:0];
    end
  end

  // *******************************************************************
  // Ethernet transmit clock on the PLL clock
  // *******************************************************************
  // The divider setting is held static while running; it is resampled
  // through two stages per bit, so change it only with the port idle.
  logic [DIV_WIDTH-1:0] div_meta;
  logic [DIV_WIDTH-1:0] div_sync;
  logic [DIV_WIDTH-1:0] tx_count;
  logic [DIV_WIDTH-1:0] next_tx_count;
  logic                 tx_clk;
  logic                 next_tx_clk;
  logic                 pll_rst_meta;
  logic                 pll_rst_b;

  always_ff @(posedge pll_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pll_rst_meta <= 1'b0;
      pll_rst_b    <= 1'b0;
      div_meta     <= '0;
      div_sync     <= '0;
    end else begin
      pll_rst_meta <= 1'b1;
      pll_rst_b    <= pll_rst_meta;
      div_meta     <= feature_control[`FC_DIV_MSB:`FC_DIV_LSB];
      div_sync     <= div_meta;
    end
  end

  // Counter wraps after reaching the divider, so the period is value plus one.
  assign next_tx_count = (tx_count >= div_sync) ? '0 : tx_count + DIV_WIDTH'(1);
  assign next_tx_clk   = (tx_count == div_sync) ? 1'b1 :
                         (tx_count == (div_sync >> 1)) ? 1'b0 : tx_clk;

  always_ff @(posedge pll_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_count         <= '0;
      tx_clk           <= 1'b0;
      rgmii_tx_clk_out <= 1'b0;
    end else begin
      tx_count         <= pll_rst_b ? next_tx_count : '0;
      tx_clk           <= pll_rst_b ? next_tx_clk : 1'b0;
      rgmii_tx_clk_out <= tx_clk;
    end
  end

  // *******************************************************************
  // Ring oscillator counters
  // *******************************************************************
  // Index 0,1 are tile cell and wire (core enable); 2,3 peripheral.
  // Software must leave them stopped for ten cycles before reading.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_osc
      ring_osc_counter #(
        .WIDTH(`OSC_COUNT_WIDTH)
      ) u_counter (
        .osc_clk_in (osc_clk_in[g]),
        .run_in     (osc_run_control[(g < 2) ? `OSC_CORE_BIT : `OSC_PERIPH_BIT]),
        .sys_clk_in (sys_clk_in),
        .count_out  (counts[g])
      );
    end
  endgenerate
endmodule : tile_status_control_regs

//--- verification/tile_status_control_regs_properties.sv
// Concurrent checks on the ports of the tile status register bank.
`timescale 1ns/1ps
`include "tile_status_params.svh"
module tile_status_control_regs_properties
  import tile_status_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_b_in,
  input wire logic        ps_write_in,
  input wire logic        ps_read_in,
  input wire logic [31:0] ps_resource_in,
  input wire logic [31:0] ps_wdata_in,
  input wire logic [31:0] ps_rdata_out,
  input wire logic        ps_rvalid_out,
  input wire logic        ps_error_out,
  input wire logic        otp_load_in,
  input wire logic [7:0]  rgmii_tx_delay_out,
  input wire logic        rgmii_ports_en_out,
  input wire logic        lp_divide_out,
  input wire logic        utmi_select_out,
  input wire logic        ulpi_hw_en_out,
  input wire logic [31:0] security_out,
  input wire logic [1:0]  osc_run_out
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  wire fc_hit  = ps_resource_in == 32'h0000_020B;
  wire osc_hit = ps_resource_in == 32'h0000_060B;
  wire cnt_hit = ps_resource_in[31:16] == 16'h0 && ps_resource_in[7:0] == 8'h0B &&
                 ps_resource_in[15:8] >= 8'h07 && ps_resource_in[15:8] <= 8'h0A;

  a_read_answer: assert property (ps_read_in && fc_hit |=> ps_rvalid_out && !ps_error_out)
    else $error("read of a mapped register gave no answer");
  a_rvalid_cause: assert property (ps_rvalid_out |-> $past(ps_read_in))
    else $error("read answer without a read");
  a_rdata_idle: assert property (!ps_rvalid_out |-> ps_rdata_out == 32'h0)
    else $error("read data not zero outside an answer");
  a_unmapped_error: assert property ((ps_read_in || ps_write_in) && ps_resource_in == 32'h0000_000B
    |=> ps_error_out && ps_rdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_fc_reserved_zero: assert property (ps_read_in && fc_hit
    |=> (ps_rdata_out & ~`FC_WRITE_MASK) == 32'h0)
    else $error("reserved control bits not zero");
  a_count_upper_zero: assert property (ps_read_in && cnt_hit |=> ps_rdata_out[31:16] == 16'h0)
    else $error("counter upper bits not zero");
  a_fc_outputs: assert property (ps_write_in && fc_hit ##1 !ps_write_in
    |=> rgmii_tx_delay_out == $past(ps_wdata_in[25:18], 2)
    && rgmii_ports_en_out == $past(ps_wdata_in[8], 2) && utmi_select_out == $past(ps_wdata_in[2], 2)
    && ulpi_hw_en_out == $past(ps_wdata_in[1], 2))
    else $error("control outputs do not follow write");
  a_static_divide: assert property (ps_write_in && fc_hit && !ps_wdata_in[5] ##1 !ps_write_in
    |=> lp_divide_out == $past(ps_wdata_in[4], 2))
    else $error("static divider output wrong");
  a_osc_run_follow: assert property (ps_write_in && osc_hit ##1 !ps_write_in
    |=> osc_run_out == $past(ps_wdata_in[1:0], 2))
    else $error("oscillator enables do not follow write");
  // The load pulse passes a synchroniser, so a quiet window on the load input is required.
  a_lock_holds: assert property (security_out[31] && !otp_load_in && !$past(otp_load_in)
    && !$past(otp_load_in, 2) && !$past(otp_load_in, 3) |=> $stable(security_out))
    else $error("locked security register changed");
endmodule : tile_status_control_regs_properties

//--- verification/tb.sv
// Self-checking testbench of the tile status register bank.
`timescale 1ns/1ps
`include "tile_status_params.svh"
module tb
  import tile_status_pkg::*;
;
  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  logic       sys_clk_in = 0, rst_b_in = 0, pll_clk = 0, otp_load = 0, paused = 0;
  logic       ps_write = 0, ps_read = 0, rvalid, error, tx_clk, ports_en, lp_div, utmi, ulpi;
  logic [3:0] osc_clk = 4'h0;
  logic [7:0] tx_dly;
  logic [1:0] osc_run;
  word_t      resource = 32'h0, wdata = 32'h0, rdata, sec, rd, cnt [4];
  int         n_mismatch = 0, cmp_count = 0, hi, per;

  initial forever #20 sys_clk_in = ~sys_clk_in;
  initial forever #7 pll_clk = ~pll_clk;
  for (genvar g = 0; g < 4; g++) begin : g_osc
    initial forever #(2 + g) osc_clk[g] = ~osc_clk[g];
  end

  tile_status_control_regs i_tile_status_control_regs (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ps_write_in(ps_write), .ps_read_in(ps_read),
    .ps_resource_in(resource), .ps_wdata_in(wdata), .ps_rdata_out(rdata), .ps_rvalid_out(rvalid),
    .ps_error_out(error), .pll_clk_in(pll_clk), .boot_report_in(32'hFF5A_FFFF),
    .otp_security_in(32'h7FFF_FFFF), .otp_load_in(otp_load), .all_threads_paused_in(paused),
    .osc_clk_in(osc_clk), .rgmii_tx_clk_out(tx_clk), .rgmii_tx_delay_out(tx_dly),
    .rgmii_ports_en_out(ports_en), .lp_divide_out(lp_div), .utmi_select_out(utmi),
    .ulpi_hw_en_out(ulpi), .security_out(sec), .osc_run_out(osc_run));

  task automatic check(input word_t seen, input word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic ps_wr(input reg_num_t r, input word_t d);
    @(negedge sys_clk_in);
    resource = {16'h0, r, `PS_RESOURCE_TYPE};
    wdata = d;
    ps_write = 1;
    @(negedge sys_clk_in);
    ps_write = 0;
  endtask : ps_wr

  task automatic ps_rd(input reg_num_t r);
    @(negedge sys_clk_in);
    resource = {16'h0, r, `PS_RESOURCE_TYPE};
    ps_read = 1;
    @(negedge sys_clk_in);
    ps_read = 0;
    rd = rdata;
  endtask : ps_rd

  task automatic rdc(input reg_num_t r, input word_t exp);
    ps_rd(r);
    check(rd, exp);
    check(word_t'(rvalid), 32'h1);
  endtask : rdc

  // Samples the transmit clock on every rising PLL edge; a bounded window, so no wait can hang.
  task automatic tx_measure();
    logic s [40];
    int a;
    a = -1;
    hi = 0;
    per = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge pll_clk);
      #1 s[i] = tx_clk;
    end
    for (int i = 1; i < 40; i++) begin
      if (s[i] === 1'b1 && s[i-1] === 1'b0) begin
        if (a < 0) a = i;
        else if (per == 0) per = i - a;
      end
      if (s[i] === 1'b0 && s[i-1] === 1'b1 && a >= 0 && hi == 0) hi = i - a;
    end
  endtask : tx_measure

  task automatic osc_cycle(input word_t en);
    ps_wr(8'h06, en);
    repeat (20) @(negedge sys_clk_in);
    ps_wr(8'h06, 32'h0);
    repeat (10) @(negedge sys_clk_in);
  endtask : osc_cycle

  initial begin
    #3_000_000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_b_in = 1;
    repeat (4) @(negedge sys_clk_in);
    rdc(8'h02, 32'h0);
    rdc(8'h06, 32'h0);
    rdc(8'h03, 32'h005A_013F);
    ps_wr(8'h03, 32'h0);
    rdc(8'h03, 32'h005A_013F);
    $display("test reset and boot report done");
    ps_wr(8'h02, 32'hFFFF_FFFF);
    rdc(8'h02, 32'h03FF_FF36);
    check(word_t'({tx_dly, ports_en, utmi, ulpi, lp_div}), 32'h0000_0FFE);
    paused = 1;
    repeat (5) @(negedge sys_clk_in);
    check(word_t'(lp_div), 32'h1);
    paused = 0;
    repeat (5) @(negedge sys_clk_in);
    check(word_t'(lp_div), 32'h0);
    ps_wr(8'h02, 32'h0204_0910);
    repeat (2) @(negedge sys_clk_in);
    check(word_t'({tx_dly, ports_en, utmi, ulpi, lp_div}), 32'h0000_0819);
    repeat (300) @(negedge sys_clk_in);
    tx_measure();
    check(word_t'(hi), 32'h3);
    check(word_t'(per), 32'h5);
    $display("test control register done");
    otp_load = 1;
    repeat (6) @(negedge sys_clk_in);
    otp_load = 0;
    repeat (6) @(negedge sys_clk_in);
    rdc(8'h05, 32'h0000_5FB1);
    check(sec, 32'h0000_5FB1);
    ps_wr(8'h05, 32'h8000_0001);
    rdc(8'h05, 32'h8000_0001);
    ps_wr(8'h05, 32'h0000_5FB0);
    rdc(8'h05, 32'h8000_0001);
    $display("test security done");
    ps_wr(8'h06, 32'hFFFF_FFFF);
    rdc(8'h06, 32'h0000_0003);
    check(word_t'(osc_run), 32'h3);
    osc_cycle(32'h3);
    for (int i = 0; i < 4; i++) begin
      ps_rd(8'h07 + i[7:0]);
      cnt[i] = rd;
      rdc(8'h07 + i[7:0], cnt[i]);
      check(rd >> 16, 32'h0);
    end
    // Only the peripheral pair may move while the core enable stays clear.
    osc_cycle(32'h1);
    for (int i = 0; i < 4; i++) begin
      ps_rd(8'h07 + i[7:0]);
      if (i < 2) check(rd, cnt[i]);
      else check(word_t'(rd !== cnt[i]), 32'h1);
      cnt[i] = rd;
    end
    rst_b_in = 0;
    repeat (4) @(negedge sys_clk_in);
    rst_b_in = 1;
    repeat (4) @(negedge sys_clk_in);
    for (int i = 0; i < 4; i++) rdc(8'h07 + i[7:0], cnt[i]);
    $display("test oscillators done");
    ps_rd(8'h00);
    check(rd, 32'h0);
    check(word_t'(error), 32'h1);
    ps_wr(8'h04, 32'hFFFF_FFFF);
    check(word_t'(error), 32'h1);
    $display("test unmapped ids done");
    give_verdict();
  end
endmodule : tb

// ****************************************************************
// Checker attachment
// ****************************************************************
bind tile_status_control_regs tile_status_control_regs_properties i_properties (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ps_write_in(ps_write_in),
  .ps_read_in(ps_read_in), .ps_resource_in(ps_resource_in), .ps_wdata_in(ps_wdata_in),
  .ps_rdata_out(ps_rdata_out), .ps_rvalid_out(ps_rvalid_out), .ps_error_out(ps_error_out),
  .otp_load_in(otp_load_in), .rgmii_tx_delay_out(rgmii_tx_delay_out),
  .rgmii_ports_en_out(rgmii_ports_en_out), .lp_divide_out(lp_divide_out),
  .utmi_select_out(utmi_select_out), .ulpi_hw_en_out(ulpi_hw_en_out),
  .security_out(security_out), .osc_run_out(osc_run_out));
